// File: design/nco_waveform_register_control.sv
// Waveform generator core: serial register load, NCO and output select.
// Assumes serial pins synchronous to core_clk_i, which is the reference.
`timescale 1ns/1ps
module nco_waveform_register_control
  import nco_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  input  wire logic serial_clk_i,
  input  wire logic serial_data_in_i,
  input  wire logic frame_sync_n_i,
  output wave_out_t wave_out_o
);

  // Received word strobe
  logic         word_valid;
  serial_word_t word;

  // Programmed state
  ctl_t               ctl;
  logic [FREQ_W-1:0]  freq_word_a;
  logic [FREQ_W-1:0]  freq_word_b;
  logic [PHASE_W-1:0] phase_offset_a;
  logic [PHASE_W-1:0] phase_offset_b;

  // Full-word staging
  logic               pend_valid;
  logic               pend_sel_b;
  logic [HALF_W-1:0]  pend_low;

  // Accumulator path
  logic [FREQ_W-1:0]  selected_freq_value;
  logic [PHASE_W-1:0] selected_phase_value;
  logic [FREQ_W-1:0]  phase_acc;
  logic [PHASE_W-1:0] phase_sum;
  logic [CODE_W-1:0]  sine_code;
  logic [CODE_W-1:0]  tri_code;
  logic [CODE_W-1:0]  next_dac_code;
  logic [CODE_W-1:0]  dac_code;
  wave_out_t          next_wave_out;
  logic               msb_prev;
  logic               msb_half;
  logic [3:0]         wake_cnt;
  logic               run;
  logic               wake_done;

  // Word decode helpers
  logic is_ctl;
  logic is_freq;
  logic is_phase;
  logic freq_to_b;

  serial_word_rx u_rx (
    .core_clk_i       (core_clk_i),
    .reset_i          (reset_i),
    .serial_clk_i     (serial_clk_i),
    .serial_data_in_i (serial_data_in_i),
    .frame_sync_n_i   (frame_sync_n_i),
    .word_valid_o     (word_valid),
    .word_o           (word)
  );

  // Tag decode of each completed word
  assign is_ctl    = word_valid & (word.tag == TAG_CONTROL);
  assign is_phase  = word_valid & (word.tag == TAG_PHASE);
  assign is_freq   = word_valid & ((word.tag == TAG_FREQ_A)
                                 | (word.tag == TAG_FREQ_B));
  assign freq_to_b = (word.tag == TAG_FREQ_B);

  // Control register; never touched by the reset bit itself
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctl <= CTL_RESET;
    end else if (is_ctl) begin
      ctl.full_word_load    <= word.body[CTL_FULL_POS];
      ctl.half_select       <= word.body[CTL_HALF_POS];
      ctl.freq_select       <= word.body[CTL_FSEL_POS];
      ctl.phase_select      <= word.body[CTL_PSEL_POS];
      ctl.nco_reset         <= word.body[CTL_RESET_POS];
      ctl.clock_stop        <= word.body[CTL_CSTOP_POS];
      ctl.converter_off     <= word.body[CTL_CONV_POS];
      ctl.bit_output_enable <= word.body[CTL_BITEN_POS];
      ctl.halving_select    <= word.body[CTL_HALVE_POS];
      ctl.tri_mode          <= word.body[CTL_MODE_POS];
    end
  end

  // Staging for the low half of a full-word load. A control write or a
  // write to the other address restarts the pair, so a stray half can
  // never be merged into the wrong register.
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pend_valid <= 1'b0;
      pend_sel_b <= 1'b0;
      pend_low   <= '0;
    end else if (is_ctl) begin
      pend_valid <= 1'b0;
    end else if (is_freq && ctl.full_word_load) begin
      if (pend_valid && (pend_sel_b == freq_to_b)) begin
        pend_valid <= 1'b0;
      end else begin
        pend_valid <= 1'b1;
        pend_sel_b <= freq_to_b;
        pend_low   <= word.body;
      end
    end
  end

  // Frequency word a: whole word on the second half, or one half alone
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      freq_word_a <= '0;
    end else if (is_freq && !freq_to_b) begin
      if (ctl.full_word_load) begin
        if (pend_valid && !pend_sel_b) begin
          freq_word_a <= {word.body, pend_low};
        end
      end else if (ctl.half_select) begin
        freq_word_a[FREQ_W-1:HALF_W] <= word.body;
      end else begin
        freq_word_a[HALF_W-1:0] <= word.body;
      end
    end
  end

  // Frequency word b, same loading scheme
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      freq_word_b <= '0;
    end else if (is_freq && freq_to_b) begin
      if (ctl.full_word_load) begin
        if (pend_valid && pend_sel_b) begin
          freq_word_b <= {word.body, pend_low};
        end
      end else if (ctl.half_select) begin
        freq_word_b[FREQ_W-1:HALF_W] <= word.body;
      end else begin
        freq_word_b[HALF_W-1:0] <= word.body;
      end
    end
  end

  // Phase offsets; body bit 12 is a don't-care
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      phase_offset_a <= '0;
      phase_offset_b <= '0;
    end else if (is_phase) begin
      if (word.body[PHASE_SEL_POS]) begin
        phase_offset_b <= word.body[PHASE_W-1:0];
      end else begin
        phase_offset_a <= word.body[PHASE_W-1:0];
      end
    end
  end

  // Selection follows the control bits at once, even while stopped
  assign selected_freq_value  = ctl.freq_select ? freq_word_b
                                                : freq_word_a;
  assign selected_phase_value = ctl.phase_select ? phase_offset_b
                                                 : phase_offset_a;

  // The internal clock is modelled as a run qualifier, not a gated clock,
  // so the register interface keeps working while the core sleeps.
  assign run       = ~ctl.clock_stop;
  assign wake_done = (wake_cnt == WAKE_LAST);

  // Accumulator: adding the word each cycle gives f = fref * word / 2^28
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      phase_acc <= '0;
    end else if (ctl.nco_reset) begin
      phase_acc <= '0;
    end else if (run) begin
      phase_acc <= phase_acc + selected_freq_value;
    end
  end

  // Top 12 accumulator bits plus offset: one step is 1/4096 cycle
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      phase_sum <= '0;
    end else if (ctl.nco_reset) begin
      phase_sum <= '0;
    end else if (run) begin
      phase_sum <= phase_acc[FREQ_W-1 -: PHASE_W]
                   + selected_phase_value;
    end
  end

  sine_table u_sine (
    .phase_i (phase_sum),
    .code_o  (sine_code)
  );

  // Triangle: fold the phase about its top bit
  always_comb begin
    if (phase_sum[PHASE_W-1]) begin
      tri_code = ~phase_sum[PHASE_W-2 -: CODE_W];
    end else begin
      tri_code = phase_sum[PHASE_W-2 -: CODE_W];
    end
  end

  // Mode picks table or triangle; bit output always uses the table, as
  // the mode bit must be low whenever bit output is enabled.
  always_comb begin
    if (ctl.tri_mode && !ctl.bit_output_enable) begin
      next_dac_code = tri_code;
    end else begin
      next_dac_code = sine_code;
    end
  end

  // Converter data register
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dac_code <= MIDSCALE;
    end else if (ctl.nco_reset) begin
      dac_code <= MIDSCALE;
    end else if (run) begin
      dac_code <= next_dac_code;
    end
  end

  // Wake counter: counts run cycles after the reset bit falls
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wake_cnt <= '0;
    end else if (ctl.nco_reset) begin
      wake_cnt <= '0;
    end else if (run && !wake_done) begin
      wake_cnt <= wake_cnt + 4'h1;
    end
  end

  // Halved MSB: toggles on each rising edge of the converter MSB
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      msb_prev <= 1'b0;
      msb_half <= 1'b0;
    end else if (ctl.nco_reset) begin
      msb_prev <= 1'b0;
      msb_half <= 1'b0;
    end else if (run) begin
      msb_prev <= dac_code[CODE_W-1];
      if (dac_code[CODE_W-1] && !msb_prev) begin
        msb_half <= ~msb_half;
      end
    end
  end

  // Next output word. Midscale until the wake count is reached; a stopped
  // clock freezes code and bit unless the reset bit is set, while pin source and converter power
  // still follow the control bits one edge later.
  always_comb begin
    next_wave_out              = wave_out_o;
    next_wave_out.converter_on = ~ctl.converter_off;
    next_wave_out.bit_on_pin   = ctl.bit_output_enable;
    if (ctl.nco_reset) begin
      next_wave_out.dac_code = MIDSCALE;
      next_wave_out.pin_bit  = 1'b0;
    end else if (run && wake_done) begin
      next_wave_out.dac_code = dac_code;
      next_wave_out.pin_bit  = ctl.halving_select ? dac_code[CODE_W-1]
                                                  : msb_half;
    end else if (run) begin
      next_wave_out.dac_code = MIDSCALE;
      next_wave_out.pin_bit  = 1'b0;
    end
  end

  // Output register; one process drives the whole port so the struct
  // fields never end up with separate drivers.
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wave_out_o.converter_on <= 1'b1;
      wave_out_o.bit_on_pin   <= 1'b0;
      wave_out_o.pin_bit      <= 1'b0;
      wave_out_o.dac_code     <= MIDSCALE;
    end else begin
      wave_out_o <= next_wave_out;
    end
  end

endmodule

// File: include/nco_pkg.sv
// Shared constants and types of the waveform generator core.
// Assumes a single core clock; serial pins are synchronous to it.
package nco_pkg;

  // Widths of the data paths
  localparam int FREQ_W  = 28;
  localparam int HALF_W  = 14;
  localparam int PHASE_W = 12;
  localparam int WORD_W  = 16;
  localparam int CODE_W  = 10;
  localparam int TABLE_W = 4;

  // Address tags in the two top bits of a serial word
  localparam logic [1:0] TAG_CONTROL = 2'h0;
  localparam logic [1:0] TAG_FREQ_A  = 2'h1;
  localparam logic [1:0] TAG_FREQ_B  = 2'h2;
  localparam logic [1:0] TAG_PHASE   = 2'h3;

  // Control word bit positions inside the 14-bit body
  localparam int CTL_FULL_POS   = 13;
  localparam int CTL_HALF_POS   = 12;
  localparam int CTL_FSEL_POS   = 11;
  localparam int CTL_PSEL_POS   = 10;
  localparam int CTL_RESET_POS  = 8;
  localparam int CTL_CSTOP_POS  = 7;
  localparam int CTL_CONV_POS   = 6;
  localparam int CTL_BITEN_POS  = 5;
  localparam int CTL_HALVE_POS  = 3;
  localparam int CTL_MODE_POS   = 1;
  localparam int PHASE_SEL_POS  = 13;

  // Serial framing
  localparam int          BIT_CNT_W  = 5;
  localparam logic [4:0]  FRAME_BITS = 5'h10;

  // Output levels and wake latency
  localparam logic [9:0] MIDSCALE    = 10'h200;
  localparam logic [3:0] WAKE_CYCLES = 4'h8;
  localparam logic [3:0] WAKE_LAST   = WAKE_CYCLES - 4'h1;

  typedef struct packed {
    logic [1:0]        tag;
    logic [HALF_W-1:0] body;
  } serial_word_t;

  typedef struct packed {
    logic full_word_load;
    logic half_select;
    logic freq_select;
    logic phase_select;
    logic nco_reset;
    logic clock_stop;
    logic converter_off;
    logic bit_output_enable;
    logic halving_select;
    logic tri_mode;
  } ctl_t;

  localparam ctl_t CTL_RESET = '0;

  typedef struct packed {
    logic              converter_on;
    logic              bit_on_pin;
    logic              pin_bit;
    logic [CODE_W-1:0] dac_code;
  } wave_out_t;

endpackage

// File: design/serial_word_rx.sv
// Serial word receiver: shifts 16 bits, MSB first, on falling edges.
// Assumes serial clock and data are synchronous to the core clock.
`timescale 1ns/1ps
module serial_word_rx
  import nco_pkg::*;
(
  input  wire logic   core_clk_i,
  input  wire logic   reset_i,
  input  wire logic   serial_clk_i,
  input  wire logic   serial_data_in_i,
  input  wire logic   frame_sync_n_i,
  output logic        word_valid_o,
  output serial_word_t word_o
);

  logic                 sclk_prev;
  logic [BIT_CNT_W-1:0] bit_cnt;
  logic [WORD_W-1:0]    shift;
  logic                 sample;

  // Falling edge of the serial clock inside an open frame
  assign sample = sclk_prev & ~serial_clk_i & ~frame_sync_n_i
                  & (bit_cnt != FRAME_BITS);

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= serial_clk_i;
    end
  end

  // Extra edges after the sixteenth are ignored until the frame closes
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      bit_cnt <= '0;
      shift   <= '0;
    end else if (frame_sync_n_i) begin
      bit_cnt <= '0;
    end else if (sample) begin
      bit_cnt <= bit_cnt + 5'h01;
      shift   <= {shift[WORD_W-2:0], serial_data_in_i};
    end
  end

  // One-cycle strobe with the completed word
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      word_valid_o <= 1'b0;
      word_o       <= '0;
    end else begin
      word_valid_o <= sample & (bit_cnt == FRAME_BITS - 5'h01);
      if (sample) begin
        word_o <= {shift[WORD_W-2:0], serial_data_in_i};
      end
    end
  end

endmodule

// File: design/sine_table.sv
// Sine lookup: phase to offset-binary 10-bit converter code.
// Quarter-wave table of 16 entries; coarse, mirrored by quadrant.
`timescale 1ns/1ps
module sine_table
  import nco_pkg::*;
(
  input  wire logic [PHASE_W-1:0] phase_i,
  output logic      [CODE_W-1:0]  code_o
);

  localparam logic [9:0] QUARTER [0:15] = '{
    10'h019, 10'h04B, 10'h07C, 10'h0AC, 10'h0DA, 10'h107, 10'h130,
    10'h157, 10'h17A, 10'h19A, 10'h1B6, 10'h1CE, 10'h1E1, 10'h1F0,
    10'h1F9, 10'h1FE};

  logic [TABLE_W-1:0] idx;
  logic [9:0]         mag;

  // Second and fourth quadrants read the table backwards
  always_comb begin
    idx = phase_i[PHASE_W-3 -: TABLE_W];
    if (phase_i[PHASE_W-2]) begin
      idx = ~idx;
    end
    mag = QUARTER[idx];
    if (phase_i[PHASE_W-1]) begin
      code_o = MIDSCALE - 10'h001 - mag;
    end else begin
      code_o = MIDSCALE + mag;
    end
  end

endmodule

// File: testbench/nco_monitor.sv
// Port checker of the waveform core; it decodes serial words itself.
// Assumes serial pins synchronous to core_clk_i, as the core does.
`timescale 1ns/1ps
module nco_monitor
  import nco_pkg::*;
(
  input wire logic      core_clk_i,
  input wire logic      reset_i,
  input wire logic      serial_clk_i,
  input wire logic      serial_data_in_i,
  input wire logic      frame_sync_n_i,
  input wire wave_out_t wave_out_o
);
  logic [4:0]  cnt;
  logic [15:0] sh;
  logic        prev_sclk;
  logic        stb;
  logic [3:0]  quiet;
  ctl_t        ctl;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  // Mirror of the receiver: one bit per falling serial edge in a frame
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      prev_sclk <= 1'b0;
      cnt       <= '0;
      sh        <= '0;
      stb       <= 1'b0;
    end else begin
      prev_sclk <= serial_clk_i;
      stb       <= 1'b0;
      if (frame_sync_n_i) begin
        cnt <= '0;
      end else if (prev_sclk && !serial_clk_i && cnt < FRAME_BITS) begin
        sh  <= {sh[14:0], serial_data_in_i};
        cnt <= cnt + 5'h1;
        stb <= (cnt == FRAME_BITS - 5'h1);
      end
    end
  end

  // Control shadow; quiet gives the core a few edges to catch up
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctl   <= CTL_RESET;
      quiet <= 4'hF;
    end else if (stb && sh[15:14] == TAG_CONTROL) begin
      ctl   <= {sh[13:10], sh[8:5], sh[3], sh[1]};
      quiet <= 4'h0;
    end else if (quiet != 4'hF) begin
      quiet <= quiet + 4'h1;
    end
  end

  property p_reset_vals;
    $fell(reset_i) |-> wave_out_o.dac_code == MIDSCALE &&
      wave_out_o.converter_on && !wave_out_o.bit_on_pin;
  endproperty
  property p_conv_on;
    quiet > 4'h3 |-> wave_out_o.converter_on == !ctl.converter_off;
  endproperty
  property p_conv_cause;
    $changed(wave_out_o.converter_on) |-> quiet < 4'h4;
  endproperty
  property p_bit_pin;
    quiet > 4'h3 |-> wave_out_o.bit_on_pin == ctl.bit_output_enable;
  endproperty
  property p_reset_mid;
    quiet > 4'h3 && ctl.nco_reset && !ctl.clock_stop |->
      wave_out_o.dac_code == MIDSCALE;
  endproperty
  property p_wake;
    $fell(ctl.nco_reset) && !ctl.clock_stop |->
      (wave_out_o.dac_code == MIDSCALE) [*7];
  endproperty
  property p_stop_hold;
    quiet > 4'h3 && ctl.clock_stop && !ctl.nco_reset |->
      $stable(wave_out_o.dac_code);
  endproperty
  property p_stop_pin;
    quiet > 4'h3 && ctl.clock_stop ##1 ctl.clock_stop |->
      $stable(wave_out_o.pin_bit);
  endproperty

  a_reset_vals: assert property (p_reset_vals)
    else $error("outputs wrong after reset");
  a_conv_on: assert property (p_conv_on)
    else $error("converter enable differs from control");
  a_conv_cause: assert property (p_conv_cause)
    else $error("converter enable moved without control write");
  a_bit_pin: assert property (p_bit_pin)
    else $error("bit output flag differs from control");
  a_reset_mid: assert property (p_reset_mid)
    else $error("code not midscale while held in reset");
  a_wake: assert property (p_wake)
    else $error("waveform came early after reset cleared");
  a_stop_hold: assert property (p_stop_hold)
    else $error("code moved while clock stopped");
  a_stop_pin: assert property (p_stop_pin)
    else $error("pin bit moved while clock stopped");

  c_phase: cover property (stb && sh[15:14] == TAG_PHASE);
  c_wake: cover property ($fell(ctl.nco_reset));
  c_stop: cover property (quiet > 4'h3 && ctl.clock_stop);
endmodule

// File: testbench/host_serial_model.sv
// Host side of the serial port: frames one 16-bit word, MSB first.
// Assumes the core samples the serial pins on core_clk_i rising edges.
`timescale 1ns/1ps
module host_serial_model (
  input  wire logic core_clk_i,
  output logic      serial_clk_o,
  output logic      serial_data_o,
  output logic      frame_sync_n_o
);
  initial begin
    serial_clk_o   = 1'b1;
    serial_data_o  = 1'b0;
    frame_sync_n_o = 1'b1;
  end

  // Each serial phase lasts 1+slow core cycles; clock idles high
  task automatic send_word(input logic [15:0] w, input int slow);
    @(posedge core_clk_i);
    frame_sync_n_o <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      serial_data_o <= w[i];
      serial_clk_o  <= 1'b1;
      repeat (1 + slow) @(posedge core_clk_i);
      serial_clk_o  <= 1'b0;
      repeat (1 + slow) @(posedge core_clk_i);
    end
    // Released data line shows the inverse, never a stale bit
    serial_data_o  <= ~w[0];
    serial_clk_o   <= 1'b1;
    frame_sync_n_o <= 1'b1;
    @(posedge core_clk_i);
  endtask
endmodule

// File: testbench/tb_nco_waveform_register_control.sv
// Self-checking bench of the waveform core through its serial port.
// Assumes the host model frames words; bind attaches the port checker.
`timescale 1ns/1ps
module tb_nco_waveform_register_control;
  import nco_pkg::*;
  localparam logic [9:0] FULL = 10'h200, HALF = 10'h100, FSEL = 10'h080;
  localparam logic [9:0] PSEL = 10'h040, RST = 10'h020, STOP = 10'h010;
  localparam logic [9:0] OFF = 10'h008, BEN = 10'h004, HALVE = 10'h002;
  localparam logic [9:0] TRI = 10'h001;
  logic        core_clk_i = 1'b0;
  logic        reset_i    = 1'b1;
  logic        sclk;
  logic        serial_data_in;
  logic        frame_sync_n_n;
  wave_out_t   wave_out;
  int          miscompares = 0;
  int          checks_done = 0;
  int          seed = 40;
  int          cycles = 0;
  int          k;
  int          k2;
  logic [11:0] p;
  logic [9:0]  held;

  always #2.5 core_clk_i = ~core_clk_i;

  nco_waveform_register_control nco_waveform_register_control_inst (
    .core_clk_i       (core_clk_i),
    .reset_i          (reset_i),
    .serial_clk_i     (sclk),
    .serial_data_in_i (serial_data_in),
    .frame_sync_n_i   (frame_sync_n_n),
    .wave_out_o       (wave_out)
  );
  host_serial_model host_serial_model_inst (
    .core_clk_i     (core_clk_i),
    .serial_clk_o   (sclk),
    .serial_data_o  (serial_data_in),
    .frame_sync_n_o (frame_sync_n_n)
  );

  task automatic check(input string what, input logic [9:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One word, then time for it to reach the output; random pacing
  task automatic put(input logic [1:0] tag, input logic [13:0] body);
    host_serial_model_inst.send_word({tag, body}, $random(seed) & 1);
    repeat (8) @(posedge core_clk_i);
    #1;
  endtask
  task automatic ctl(input logic [9:0] c);
    put(TAG_CONTROL,
        {c[9:6], 1'b0, c[5:2], 1'b0, c[1], 1'b0, c[0], 1'b0});
  endtask
  function automatic logic [9:0] tri_code(input logic [11:0] ph);
    return ph[11] ? ~ph[10:1] : ph[10:1];
  endfunction
  // Triangle slope: steps of k..k+extra, samples near the folds excused
  task automatic tri_run(input int k, input int extra);
    int a;
    int b;
    int d;
    b = wave_out.dac_code;
    repeat (40) begin
      @(posedge core_clk_i);
      #1;
      a = b;
      b = wave_out.dac_code;
      d = (b > a) ? b - a : a - b;
      if (a > 2 * k + 1 && b > 2 * k + 1 && a < 1021 - 2 * k &&
          b < 1021 - 2 * k) begin
        check("slope", 10'h1, {9'h0, d >= k && d <= k + extra});
      end
    end
  endtask
  // Rising edges of the converter MSB and of the pin bit in one window
  task automatic rises(output int m, output int q);
    logic pm;
    logic pq;
    m = 0;
    q = 0;
    repeat (3000) begin
      pm = wave_out.dac_code[9];
      pq = wave_out.pin_bit;
      @(posedge core_clk_i);
      #1;
      m += int'(wave_out.dac_code[9] && !pm);
      q += int'(wave_out.pin_bit && !pq);
    end
  endtask

  initial begin
    int m;
    int q;
    repeat (20) @(posedge core_clk_i);
    reset_i <= 1'b0;
    @(posedge core_clk_i);
    #1;
    check("idle code", MIDSCALE, wave_out.dac_code);
    check("idle flags", 10'h2, {8'h0, wave_out.converter_on,
                                wave_out.bit_on_pin});
    ctl(FSEL | PSEL | RST | TRI);
    ctl(FSEL | PSEL | TRI);
    for (int i = 0; i < 6; i++) begin
      p = 12'($random(seed));
      put(TAG_PHASE, {1'b1, p[0], p});
      check("phase b", tri_code(p), wave_out.dac_code);
    end
    p = 12'($random(seed));
    put(TAG_PHASE, {2'b00, p});
    ctl(FSEL | TRI);
    check("phase a", tri_code(p), wave_out.dac_code);
    ctl(FSEL | PSEL);
    put(TAG_PHASE, 14'h2400);
    check("sine top", 10'h1, {9'h0, wave_out.dac_code > 10'h300});
    put(TAG_PHASE, 14'h2C00);
    check("sine low", 10'h1, {9'h0, wave_out.dac_code < 10'h100});
    $display("test phase and shape done");
    k = 4 + ($unsigned($random(seed)) % 12);
    ctl(FULL | RST | TRI);
    check("held", MIDSCALE, wave_out.dac_code);
    put(TAG_FREQ_B, 14'h3FFF); // odd half dropped by the next address
    put(TAG_FREQ_A, 14'h0000);
    put(TAG_FREQ_A, 14'(k * 8));
    ctl(FULL | TRI);
    tri_run(k, 0);
    ctl(FULL | RST | TRI);
    check("held again", MIDSCALE, wave_out.dac_code);
    ctl(TRI);
    tri_run(k, 0);
    k2 = 1 + ($unsigned($random(seed)) % 15);
    ctl(HALF | TRI);
    put(TAG_FREQ_B, 14'(k2 * 8));
    ctl(TRI);
    put(TAG_FREQ_B, 14'h3FFF);
    ctl(FSEL | TRI);
    tri_run(k2, 1);
    $display("test frequency load done");
    ctl(FSEL | STOP | TRI);
    held = wave_out.dac_code;
    ctl(STOP | TRI);
    check("frozen", held, wave_out.dac_code);
    ctl(TRI);
    tri_run(k, 0);
    for (int i = 0; i < 4; i++) begin
      ctl(TRI | (i[0] ? OFF : 10'h0) | (i[1] ? STOP : 10'h0));
      check("conv on", {9'h0, !i[0]}, {9'h0, wave_out.converter_on});
    end
    $display("test sleep done");
    for (int h = 1; h >= 0; h--) begin
      ctl(BEN | (h[0] ? HALVE : 10'h0) | OFF);
      rises(m, q);
      check("pin flag", 10'h1, {9'h0, wave_out.bit_on_pin});
      check("pin rate", 10'h1, {9'h0, m > 2 &&
        q >= (h == 1 ? m : m / 2) - 1 && q <= (h == 1 ? m : m / 2) + 1});
    end
    $display("test bit output done");
    give_verdict();
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Hang guard, well above the length of the whole sequence
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      give_verdict();
    end
  end
endmodule

bind nco_waveform_register_control nco_monitor nco_monitor_inst (
  .core_clk_i       (core_clk_i),
  .reset_i          (reset_i),
  .serial_clk_i     (serial_clk_i),
  .serial_data_in_i (serial_data_in_i),
  .frame_sync_n_i   (frame_sync_n_i),
  .wave_out_o       (wave_out_o)
);
